// File: pkg/spdwp_pkg.sv
// Constants and carrier types for the write-protect acknowledge decision block
package spdwp_pkg;
   localparam logic [3:0] NIB_ARRAY  = 4'ha;   // Control nibble for normal array access
   localparam logic [3:0] NIB_LOCK   = 4'h6;   // Control nibble for lock commands and queries
   localparam logic [2:0] SEL_REV    = 3'h1;   // Bits 3..1 of set or query reversible lock
   localparam logic [2:0] SEL_CLR    = 3'h3;   // Bits 3..1 of clear reversible lock
   localparam logic [1:0] STRAP_SET  = 2'h0;   // Straps two and one for set or query reversible
   localparam logic [1:0] STRAP_CLR  = 2'h1;   // Straps two and one for clear reversible
   localparam int         UPPER_BIT  = 7;      // Address bit that selects the upper half
   localparam int         RW_BIT     = 0;      // Read/write select bit of the control byte
   localparam logic       PERM_RST   = 1'b0;   // Flag values loaded by reset
   localparam logic       REV_RST    = 1'b0;

   typedef enum {ST_IDLE, ST_CTRL, ST_ARR_ADDR, ST_ARR_DATA, ST_LOCK_DATA, ST_READ,
                 ST_SINK} spdwp_state_t;
   typedef enum {CMD_NONE, CMD_SET_PERM, CMD_SET_REV, CMD_CLR_REV} spdwp_cmd_t;

   typedef struct packed {
      logic valid;   // An acknowledge slot is being answered
      logic ack;     // 1 drives acknowledge, 0 leaves it unacknowledged
   } spdwp_ack_t;

   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] data;
   } spdwp_wr_t;
endpackage

// File: core/spdwp_core.sv
// Acknowledge and write-permission decision for array and lock-flag commands
//
// Behaviour
// - No pin protect, lock set: upper-half writes acknowledged and written.
// - Permanent lock set: lower-half write address acked, data refused, no write.
// - Reversible lock set: lower-half write address acked, data refused, no write.
// - No locks, pin low: writes acknowledged and performed anywhere.
// - Permanent-lock query refused at command byte when permanent lock set.
// - Permanent-lock query acknowledged when permanent lock clear.
// - Reversible-lock query refused at command byte when reversible lock set.
// - Reversible-lock query acknowledged when reversible lock clear.
// - Pin low, permanent clear: set-permanent acked twice, sets flag forever.
// - Pin low, both clear: set-reversible acked twice, sets reversible flag.
// - Pin low, permanent clear: clear-reversible acked twice, clears flag.
// - Permanent set: all three lock commands refused on both bytes, no change.
// - Set-reversible while reversible set refused on both bytes.
// - Pin high: array writes acked at address, refused at data, no write.
// - Pin high: set commands acked at command byte, refused at data, no change.
// - Pin high: clear-reversible acked at command, refused at data, no change.
// - Control nibble Ah for array access, 6h for lock commands and queries.
// - Lock flags protect lower half only; pin protects whole array.
`timescale 1ns/1ps
module spdwp_core (
   input  wire logic              i_clk,
   input  wire logic              i_arst_n,
   input  wire logic              i_start,
   input  wire logic              i_byte_valid,
   input  wire logic [7:0]        i_byte,
   input  wire logic              i_wp_pin,
   input  wire logic [2:0]        i_strap_bits,
   input  wire logic              i_strap0_high_voltage,
   output spdwp_pkg::spdwp_ack_t  o_ack,
   output spdwp_pkg::spdwp_wr_t   o_wr,
   output logic                   o_permanent_lock_flag,
   output logic                   o_reversible_lock_flag
);
   import spdwp_pkg::*;

   logic [1:0]   rst_sync_reg;
   logic         rst_n;
   logic [4:0]   pin_meta_reg;
   logic [4:0]   pin_sync_reg;
   logic         wp_s;
   logic [2:0]   strap_s;
   logic         hv_s;

   spdwp_state_t state_reg, state_next;
   spdwp_cmd_t   cmd_reg, cmd_next;
   logic [7:0]   addr_reg, addr_next;
   logic         perm_reg, perm_next;
   logic         rev_reg, rev_next;
   spdwp_ack_t   ack_reg, ack_next;
   spdwp_wr_t    wr_reg, wr_next;
   logic         take;
   logic         prot;

   // Reset is released synchronously so every flop leaves reset on the same edge
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // Pins are asynchronous to the clock; two flops before any decision reads them
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_reg <= 5'h0;
         pin_sync_reg <= 5'h0;
      end else begin
         pin_meta_reg <= {i_wp_pin, i_strap_bits, i_strap0_high_voltage};
         pin_sync_reg <= pin_meta_reg;
      end
   end
   assign wp_s    = pin_sync_reg[4];
   assign strap_s = pin_sync_reg[3:1];
   assign hv_s    = pin_sync_reg[0];

   assign take = i_byte_valid && !i_start;
   // Locks guard only the lower half; the pin guards everything
   assign prot = wp_s || ((perm_reg || rev_reg) && !addr_reg[UPPER_BIT]);

   always_comb begin
      state_next = state_reg;
      cmd_next   = cmd_reg;
      addr_next  = addr_reg;
      perm_next  = perm_reg;
      rev_next   = rev_reg;
      ack_next   = '0;
      wr_next    = '0;
      if (i_start) begin
         state_next = ST_CTRL;
         cmd_next   = CMD_NONE;
      end else if (i_byte_valid) begin
         ack_next.valid = 1'b1;
         case (state_reg)
            ST_CTRL: begin
               state_next = ST_IDLE;
               if (i_byte[7:4] == NIB_ARRAY && i_byte[3:1] == strap_s) begin
                  ack_next.ack = 1'b1;
                  state_next   = i_byte[RW_BIT] ? ST_READ : ST_ARR_ADDR;
               end else if (i_byte[7:4] == NIB_LOCK) begin
                  if (hv_s && i_byte[3:1] == SEL_REV && strap_s[2:1] == STRAP_SET) begin
                     if (i_byte[RW_BIT]) begin
                        ack_next.ack = !rev_reg;
                        state_next   = ack_next.ack ? ST_READ : ST_IDLE;
                     end else begin
                        ack_next.ack = !perm_reg && !rev_reg;
                        cmd_next     = CMD_SET_REV;
                        state_next   = ack_next.ack ? ST_LOCK_DATA : ST_SINK;
                     end
                  end else if (hv_s && i_byte[3:1] == SEL_CLR && strap_s[2:1] == STRAP_CLR
                               && !i_byte[RW_BIT]) begin
                     ack_next.ack = !perm_reg;
                     cmd_next     = CMD_CLR_REV;
                     state_next   = ack_next.ack ? ST_LOCK_DATA : ST_SINK;
                  end else if (!hv_s && i_byte[3:1] == strap_s) begin
                     ack_next.ack = !perm_reg;
                     if (i_byte[RW_BIT]) begin
                        state_next = ack_next.ack ? ST_READ : ST_IDLE;
                     end else begin
                        cmd_next   = CMD_SET_PERM;
                        state_next = ack_next.ack ? ST_LOCK_DATA : ST_SINK;
                     end
                  end
               end
            end
            ST_ARR_ADDR: begin
               ack_next.ack = 1'b1;
               addr_next    = i_byte;
               state_next   = ST_ARR_DATA;
            end
            ST_ARR_DATA: begin
               ack_next.ack = !prot;
               wr_next.we   = !prot;
               wr_next.addr = addr_reg;
               wr_next.data = i_byte;
               // Page writes wrap inside the sixteen-byte row
               addr_next    = {addr_reg[7:4], addr_reg[3:0] + 4'h1};
            end
            ST_LOCK_DATA: begin
               // Pin high acks the command byte but refuses the data byte
               ack_next.ack = !wp_s;
               state_next   = ST_SINK;
               if (!wp_s) begin
                  case (cmd_reg)
                     CMD_SET_PERM: perm_next = 1'b1;
                     CMD_SET_REV:  rev_next  = 1'b1;
                     CMD_CLR_REV:  rev_next  = 1'b0;
                     default:      ack_next.ack = 1'b0;
                  endcase
               end
            end
            ST_READ: begin
               // Read data slots are answered by the master, not here
               ack_next.valid = 1'b0;
            end
            default: begin
               ack_next.ack = 1'b0;
            end
         endcase
      end
   end

   // The permanent flag has no path back to zero once set
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         cmd_reg   <= CMD_NONE;
         addr_reg  <= 8'h00;
         perm_reg  <= PERM_RST;
         rev_reg   <= REV_RST;
         ack_reg   <= '0;
         wr_reg    <= '0;
      end else begin
         state_reg <= state_next;
         cmd_reg   <= cmd_next;
         addr_reg  <= addr_next;
         perm_reg  <= perm_next;
         rev_reg   <= rev_next;
         ack_reg   <= ack_next;
         wr_reg    <= wr_next;
      end
   end

   assign o_ack                  = ack_reg;
   assign o_wr                   = wr_reg;
   assign o_permanent_lock_flag  = perm_reg;
   assign o_reversible_lock_flag = rev_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   sequence s_arr_data;
      state_reg == ST_ARR_DATA && take;
   endsequence
   sequence s_lock_data;
      state_reg == ST_LOCK_DATA && take;
   endsequence
   sequence s_ctrl_perm;
      state_reg == ST_CTRL && take && i_byte[7:4] == NIB_LOCK && !hv_s
         && i_byte[3:1] == strap_s;
   endsequence
   sequence s_refused;
      o_ack.valid && !o_ack.ack && !o_wr.we;
   endsequence

   a_upper_write: assert property (s_arr_data ##0 (!wp_s && addr_reg[UPPER_BIT])
      |=> o_ack.ack && o_wr.we && o_wr.addr[UPPER_BIT])
      else $error("Upper-half write not accepted");
   a_lower_locked: assert property (s_arr_data ##0 ((perm_reg || rev_reg)
      && !addr_reg[UPPER_BIT]) |=> s_refused)
      else $error("Locked lower-half write accepted");
   a_open_write: assert property (s_arr_data ##0 (!wp_s && !perm_reg && !rev_reg)
      |=> o_ack.ack && o_wr.we && o_wr.data == $past(i_byte))
      else $error("Unlocked write not performed");
   a_pin_write: assert property (s_arr_data ##0 wp_s |=> s_refused)
      else $error("Write accepted while pin protects");
   a_perm_query: assert property (s_ctrl_perm ##0 i_byte[RW_BIT]
      |=> o_ack.valid && o_ack.ack == !$past(perm_reg))
      else $error("Permanent query answer wrong");
   a_rev_query: assert property (state_reg == ST_CTRL && take && hv_s
      && i_byte == {NIB_LOCK, SEL_REV, 1'b1} && strap_s[2:1] == STRAP_SET
      |=> o_ack.valid && o_ack.ack == !$past(rev_reg))
      else $error("Reversible query answer wrong");
   a_perm_sticky: assert property (perm_reg |=> perm_reg)
      else $error("Permanent flag cleared");
   a_lock_set: assert property (s_lock_data ##0 (!wp_s && cmd_reg == CMD_SET_REV)
      |=> o_ack.ack && rev_reg ##1 state_reg != ST_LOCK_DATA)
      else $error("Set reversible not applied");
   a_lock_clear: assert property (s_lock_data ##0 (!wp_s && cmd_reg == CMD_CLR_REV)
      |=> o_ack.ack && !rev_reg)
      else $error("Clear reversible not applied");
   a_perm_refuse: assert property (state_reg == ST_CTRL && take && perm_reg
      && i_byte[7:4] == NIB_LOCK && !i_byte[RW_BIT]
      |=> !o_ack.ack ##1 (state_reg != ST_LOCK_DATA) [*2])
      else $error("Lock command accepted while permanent lock set");
   a_pin_lock: assert property (s_lock_data ##0 wp_s
      |=> !o_ack.ack && $stable(perm_reg) && $stable(rev_reg))
      else $error("Lock flag changed while pin protects");
   a_array_read: assert property (state_reg == ST_CTRL && take
      && i_byte == {NIB_ARRAY, strap_s, 1'b1} |=> o_ack.ack ##0 state_reg == ST_READ)
      else $error("Array read not acknowledged");

   // Reversible pair: both need the high-voltage strap and fixed strap levels
   sequence s_ctrl_set_rev;
      state_reg == ST_CTRL && take && hv_s && i_byte == {NIB_LOCK, SEL_REV, 1'b0}
         && strap_s[2:1] == STRAP_SET;
   endsequence
   sequence s_ctrl_clr_rev;
      state_reg == ST_CTRL && take && hv_s && i_byte == {NIB_LOCK, SEL_CLR, 1'b0}
         && strap_s[2:1] == STRAP_CLR;
   endsequence
   sequence s_accepted;
      o_ack.valid && o_ack.ack;
   endsequence

   a_ctrl_answer: assert property (state_reg == ST_CTRL && take
      |=> o_ack.valid)
      else $error("Control byte left unanswered");
   a_addr_slot: assert property (state_reg == ST_ARR_ADDR && take
      |=> s_accepted ##0 !o_wr.we)
      else $error("Word address byte not acknowledged");
   a_stray_write: assert property (!(state_reg == ST_ARR_DATA && take)
      |=> !o_wr.we)
      else $error("Array written outside a data byte");
   a_wr_answer: assert property (o_wr.we |-> s_accepted)
      else $error("Array written under a refused byte");
   // Page writes wrap inside their row, so an upper-half page never reaches the lower half
   a_row_kept: assert property (s_arr_data |=> $stable(addr_reg[7:4]))
      else $error("Page write left its row");
   a_ctrl_refuse: assert property (state_reg == ST_CTRL && take
      && i_byte[7:4] != NIB_ARRAY && i_byte[7:4] != NIB_LOCK
      |=> o_ack.valid && !o_ack.ack ##0 state_reg == ST_IDLE)
      else $error("Foreign control byte acknowledged");
   a_strap_miss: assert property (state_reg == ST_CTRL && take
      && i_byte[7:4] == NIB_ARRAY && i_byte[3:1] != strap_s
      |=> o_ack.valid && !o_ack.ack)
      else $error("Array control byte with foreign straps acknowledged");
   a_sink_refuse: assert property (state_reg == ST_SINK && take
      |=> o_ack.valid && !o_ack.ack)
      else $error("Byte after a finished lock command acknowledged");
   a_read_quiet: assert property (state_reg == ST_READ && take
      |=> !o_ack.valid && !o_wr.we)
      else $error("Read data slot answered or written");

   a_perm_set: assert property (s_lock_data ##0 (!wp_s && cmd_reg == CMD_SET_PERM)
      |=> s_accepted ##0 perm_reg)
      else $error("Set permanent not applied");
   a_rev_twice: assert property (s_ctrl_set_rev ##0 (rev_reg && !perm_reg)
      |=> o_ack.valid && !o_ack.ack ##1 state_reg != ST_LOCK_DATA)
      else $error("Second set reversible accepted");
   a_set_rev_pin: assert property (s_ctrl_set_rev ##0 (wp_s && !perm_reg && !rev_reg)
      |=> s_accepted ##0 state_reg == ST_LOCK_DATA)
      else $error("Set reversible command byte refused under pin");
   a_clr_pin: assert property (s_ctrl_clr_rev ##0 (wp_s && !perm_reg)
      |=> s_accepted ##0 state_reg == ST_LOCK_DATA)
      else $error("Clear reversible command byte refused under pin");
   a_perm_freeze: assert property (perm_reg |=> $stable(rev_reg))
      else $error("Reversible flag changed under permanent lock");
endmodule

// File: bench/spdwp_master.sv
// Bus master model handing received bytes and start marks to the decision block
`timescale 1ns/1ps
module spdwp_master
   import spdwp_pkg::*;
(
   input  wire logic       i_clk,
   input  wire spdwp_ack_t i_ack,
   input  wire spdwp_wr_t  i_wr,
   output logic            o_start,
   output logic            o_byte_valid,
   output logic [7:0]      o_byte
);
   initial begin
      o_start      = 1'b0;
      o_byte_valid = 1'b0;
      o_byte       = 8'h00;
   end

   task automatic start_frame();
      @(posedge i_clk);
      o_start <= 1'b1;
      @(posedge i_clk);
      o_start <= 1'b0;
   endtask

   // Caller picks nibble Ah, 6h or a foreign one such as Bh, rw bit and strap pattern of each command
   task automatic send(input logic [7:0] b, output spdwp_ack_t a, output spdwp_wr_t w);
      a = '0;
      w = '0;
      @(posedge i_clk);
      o_byte_valid <= 1'b1;
      o_byte       <= b;
      @(posedge i_clk);
      o_byte_valid <= 1'b0;
      // Released line shows the inverse so a stale byte cannot pass for a fresh one
      o_byte       <= ~b;
      for (int i = 0; i < 3; i++) begin
         #1;
         if (i_ack.valid === 1'b1 && a.valid !== 1'b1) begin
            a = i_ack;
            w = i_wr;
         end
         @(posedge i_clk);
      end
   endtask
endmodule

// File: bench/spdwp_core_tb_top.sv
// Self-checking bench for the write-protect acknowledge decision block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module spdwp_core_tb_top;
   import spdwp_pkg::*;
   logic       i_clk;
   logic       i_arst_n;
   logic       i_wp_pin;
   logic [2:0] i_strap_bits;
   logic       i_hv;
   logic       start;
   logic       byte_valid;
   logic [7:0] byte_in;
   spdwp_ack_t ack;
   spdwp_wr_t  wr;
   logic       perm;
   logic       rev;
   int         error_cnt;
   int         n_compared;

   spdwp_core spdwp_core_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_start(start),
      .i_byte_valid(byte_valid), .i_byte(byte_in), .i_wp_pin(i_wp_pin),
      .i_strap_bits(i_strap_bits), .i_strap0_high_voltage(i_hv), .o_ack(ack), .o_wr(wr),
      .o_permanent_lock_flag(perm), .o_reversible_lock_flag(rev));
   spdwp_master spdwp_master_inst (.i_clk(i_clk), .i_ack(ack), .i_wr(wr), .o_start(start),
      .o_byte_valid(byte_valid), .o_byte(byte_in));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic give_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Pins pass two sync flops, so settle them before the next frame
   task automatic pins(input logic wp, input logic [2:0] s, input logic hv);
      @(posedge i_clk);
      i_wp_pin     <= wp;
      i_strap_bits <= s;
      i_hv         <= hv;
      repeat (3) @(posedge i_clk);
   endtask

   task automatic chk(input logic [7:0] c, d0, d1, input int n, input logic [2:0] eak,
                      input logic [16:0] ewr);
      logic [7:0]  b [3];
      logic [2:0]  ak;
      logic [2:0]  vl;
      logic [2:0]  vx;
      logic [16:0] wv;
      spdwp_ack_t  a;
      spdwp_wr_t   w;
      b  = '{c, d0, d1};
      ak = '0;
      vl = '0;
      wv = '0;
      // Every byte gets an answer slot, except read data after an acknowledged read
      vx = (c[RW_BIT] && eak[0]) ? 3'h1 : 3'((1 << n) - 1);
      spdwp_master_inst.start_frame();
      for (int i = 0; i < n; i++) begin
         spdwp_master_inst.send(b[i], a, w);
         ak[i] = a.valid & a.ack;
         vl[i] = a.valid;
         if (w.we === 1'b1) wv = w;
      end
      `CHK("acks", eak, ak)
      `CHK("answers", vx, vl)
      `CHK("write", ewr, wv)
   endtask

   task automatic t_open();
      pins(1'b0, 3'h0, 1'b0);
      chk(8'ha0, 8'h10, 8'h5a, 3, 3'h7, 17'h1105a);
      chk(8'ha1, 8'h00, 8'h00, 2, 3'h1, 17'h0);
      chk(8'hb0, 8'h10, 8'h5a, 3, 3'h0, 17'h0);
      chk(8'h61, 8'h00, 8'h00, 1, 3'h1, 17'h0);
      pins(1'b0, 3'h0, 1'b1);
      chk(8'h63, 8'h00, 8'h00, 1, 3'h1, 17'h0);
      $display("t_open done");
   endtask

   task automatic t_rev();
      chk(8'h62, 8'h00, 8'h00, 2, 3'h3, 17'h0);
      `CHK("rev_flag", 1'b1, rev)
      chk(8'h62, 8'h00, 8'h00, 2, 3'h0, 17'h0);
      chk(8'h63, 8'h00, 8'h00, 1, 3'h0, 17'h0);
      pins(1'b0, 3'h0, 1'b0);
      chk(8'ha0, 8'h10, 8'h5a, 3, 3'h3, 17'h0);
      chk(8'ha0, 8'h90, 8'h5a, 3, 3'h7, 17'h1905a);
      $display("t_rev done");
   endtask

   task automatic t_pin_high();
      pins(1'b1, 3'h0, 1'b0);
      chk(8'ha0, 8'h90, 8'h5a, 3, 3'h3, 17'h0);
      chk(8'ha1, 8'h00, 8'h00, 1, 3'h1, 17'h0);
      chk(8'h60, 8'h00, 8'h00, 2, 3'h1, 17'h0);
      pins(1'b1, 3'h2, 1'b1);
      chk(8'ha0, 8'h90, 8'h5a, 3, 3'h0, 17'h0);
      chk(8'h66, 8'h00, 8'h00, 2, 3'h1, 17'h0);
      `CHK("rev_flag", 1'b1, rev)
      pins(1'b0, 3'h2, 1'b1);
      chk(8'h66, 8'h00, 8'h00, 2, 3'h3, 17'h0);
      `CHK("rev_flag", 1'b0, rev)
      pins(1'b1, 3'h0, 1'b1);
      chk(8'h62, 8'h00, 8'h00, 2, 3'h1, 17'h0);
      `CHK("flags", 2'h0, {perm, rev})
      $display("t_pin_high done");
   endtask

   task automatic t_perm();
      pins(1'b0, 3'h0, 1'b0);
      chk(8'h60, 8'h00, 8'h00, 2, 3'h3, 17'h0);
      chk(8'h61, 8'h00, 8'h00, 1, 3'h0, 17'h0);
      chk(8'ha0, 8'h7f, 8'h5a, 3, 3'h3, 17'h0);
      chk(8'ha0, 8'h80, 8'h5a, 3, 3'h7, 17'h1805a);
      pins(1'b0, 3'h0, 1'b1);
      chk(8'h62, 8'h00, 8'h00, 2, 3'h0, 17'h0);
      pins(1'b0, 3'h2, 1'b1);
      chk(8'h66, 8'h00, 8'h00, 2, 3'h0, 17'h0);
      pins(1'b1, 3'h0, 1'b0);
      chk(8'h60, 8'h00, 8'h00, 2, 3'h0, 17'h0);
      chk(8'h61, 8'h00, 8'h00, 1, 3'h0, 17'h0);
      `CHK("flags", 2'h2, {perm, rev})
      $display("t_perm done");
   endtask

   initial begin
      i_arst_n     = 1'b0;
      i_wp_pin     = 1'b0;
      i_strap_bits = 3'h0;
      i_hv         = 1'b0;
      error_cnt    = 0;
      n_compared   = 0;
      repeat (16) @(posedge i_clk);
      i_arst_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      t_open();
      t_rev();
      t_pin_high();
      t_perm();
      give_verdict();
   end

   // Whole run needs about 375 cycles; a hang is cut well beyond that
   initial begin
      repeat (20000) @(posedge i_clk);
      error_cnt++;
      give_verdict();
   end
endmodule
